//--- design/iocd_top.sv
`timescale 1ns/100ps
// Functional notes
// - masked lines are edge-detected; any change emits a sample at once.
// - changes while asleep never produce a sample.
// - with periodic sampling on, a sample is emitted on wake.
// - period zero disables periodic sampling; otherwise sample every period ms.
// - sample from matching source drives enabled outputs to sender levels.
// - source address gates output updates, and host frames when enable is 0; other samples still handled.
// - source address all ones matches any sender.
// - each passing pin reverts to configured state when its timeout expires.
// - timeout counts in 100 ms units.
// - only ten general and three extra pins take part in passing.
// - passing works in both framed and transparent modes.
// - in framed mode frame goes to host unless enable is 0 and passing hit.
// - non-matching samples always go to the host in framed mode.
// - transparent mode discards samples unless passing; framed mode forwards.
// - nonzero sleep setting means asleep; lines take low-current setup.
// - outputs keep levels in sleep; inputs stay under pull settings.
// - in sleep peripheral pins go low, except clear-to-send; SPI pins high.
// - passed levels hold in sleep; their timeouts pause and resume.
// - serial bytes are buffered; new bytes dropped when buffer is full.
// - clear-to-send deasserts when the receive buffer is nearly full.
// - radio packets dropped whole when transmit and system buffers lack room.
module iocd_top
  import iocd_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [SLEEP_W-1:0] sleep_mode_setting_in,
  input wire logic api_mode_in,
  input wire logic [NUM_PINS-1:0] change_detect_mask_in,
  input wire logic [PERIOD_W-1:0] sample_period_ms_in,
  input wire logic [ADDR_W-1:0] input_source_address_in,
  input wire logic sample_output_enable_in,
  input wire logic [NUM_PINS-1:0][1:0] pin_mode_in,
  input wire logic [NUM_PINS-1:0][TMO_W-1:0] pass_timeout_in,
  input wire logic [NUM_PINS-1:0] pull_enable_mask_in,
  input wire logic [NUM_PINS-1:0] pull_direction_mask_in,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_out,
  output logic [NUM_PINS-1:0] pin_pull_en_out,
  output logic [NUM_PINS-1:0] pin_pull_up_out,
  output logic sample_valid_out,
  output logic [NUM_PINS-1:0] sample_data_out,
  input wire logic rx_sample_valid_in,
  input wire logic [ADDR_W-1:0] rx_sample_src_in,
  input wire logic [NUM_PINS-1:0] rx_sample_mask_in,
  input wire logic [NUM_PINS-1:0] rx_sample_data_in,
  output logic host_frame_valid_out,
  output logic [ADDR_W-1:0] host_frame_src_out,
  output logic [NUM_PINS-1:0] host_frame_mask_out,
  output logic [NUM_PINS-1:0] host_frame_data_out,
  output logic line_pass_hit_out,
  input wire logic ser_rx_valid_in,
  input wire logic [7:0] ser_rx_byte_in,
  output logic ser_rx_drop_out,
  output logic ser_byte_valid_out,
  output logic [7:0] ser_byte_out,
  input wire logic ser_byte_ready_in,
  output logic cts_n_out,
  input wire logic rf_pkt_valid_in,
  input wire logic [PKT_LEN_W-1:0] rf_pkt_len_in,
  output logic rf_pkt_accept_out,
  output logic rf_pkt_drop_out,
  input wire logic ser_tx_byte_sent_in,
  output logic [TXB_CNT_W-1:0] tx_level_out,
  input wire logic [PERIPH_W-1:0] periph_func_in,
  output logic [PERIPH_W-1:0] periph_out,
  input wire logic [SPI_W-1:0] spi_func_in,
  output logic [SPI_W-1:0] spi_out,
  output logic asleep_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rst_sync_r;
  logic asleep;
  logic asleep_r;
  logic wake;
  logic ms_tick;
  logic [NUM_PINS-1:0][UNIT_CNT_W-1:0] unit_ms_r;
  logic [NUM_PINS-1:0] pin_prev_r;
  logic [NUM_PINS-1:0] changed;
  logic [PERIOD_W-1:0] ms_cnt_r;
  logic period_hit;
  logic wake_hit;
  logic sample_fire;
  logic src_match;
  logic pass_hit;
  logic [NUM_PINS-1:0] pass_load;
  logic [NUM_PINS-1:0] pass_active_r;
  logic [NUM_PINS-1:0] pass_level_r;
  logic [NUM_PINS-1:0][TMO_W-1:0] tmo_cnt_r;
  logic forward;
  logic [TXB_CNT_W-1:0] tx_level_r;
  logic [TXB_CNT_W-1:0] tx_free;
  logic tx_fits;
  logic tx_dec;

  iocd_buf_if rxb ();

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep state
  assign asleep = (sleep_mode_setting_in != SLEEP_AWAKE);
  assign wake = asleep_r && !asleep;
  assign asleep_out = asleep_r;

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      asleep_r <= 1'b0;
    end else if (ce_in) begin
      asleep_r <= asleep;
    end
  end

  iocd_tick #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_r),
    .ce_in(ce_in),
    .run_in(!asleep),
    .ms_tick_out(ms_tick),
    .unit_tick_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // sample generation
  // prev copy tracks in sleep, so a sleep edge
  // never fires after wake
  assign changed = (pin_in ^ pin_prev_r) & change_detect_mask_in;
  assign period_hit = ms_tick && (sample_period_ms_in != PERIOD_OFF)
                      && (ms_cnt_r + 1'b1 >= sample_period_ms_in);
  assign wake_hit = wake && (sample_period_ms_in != PERIOD_OFF);
  assign sample_fire = !asleep && ((|changed) || period_hit || wake_hit);

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pin_prev_r <= '0;
    end else if (ce_in) begin
      pin_prev_r <= pin_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ms_cnt_r <= '0;
    end else if (ce_in) begin
      if (wake || sample_period_ms_in == PERIOD_OFF) begin
        ms_cnt_r <= '0;
      end else if (ms_tick) begin
        ms_cnt_r <= period_hit ? '0 : ms_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sample_valid_out <= 1'b0;
      sample_data_out <= '0;
    end else if (ce_in) begin
      sample_valid_out <= sample_fire;
      if (sample_fire) begin
        sample_data_out <= pin_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line passing
  assign src_match = (input_source_address_in == BROADCAST_ADDR)
                     || (rx_sample_src_in == input_source_address_in);
  assign pass_hit = rx_sample_valid_in && src_match;

  // only output-mode pins are passed
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pass_load[i] = pass_hit && rx_sample_mask_in[i]
                     && iocd_is_output(pin_mode_in[i]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pass_active_r <= '0;
      pass_level_r <= '0;
      tmo_cnt_r <= '0;
      unit_ms_r <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (pass_load[i]) begin
          pass_active_r[i] <= 1'b1;
          pass_level_r[i] <= rx_sample_data_in[i];
          tmo_cnt_r[i] <= pass_timeout_in[i];
          unit_ms_r[i] <= '0;
        end else if (!iocd_is_output(pin_mode_in[i])) begin
          pass_active_r[i] <= 1'b0;
        end else if (ms_tick && pass_active_r[i]
                     && tmo_cnt_r[i] != TMO_HOLD) begin
          // own ms count from load, so no unit is cut short; ms_tick stops asleep
          if (unit_ms_r[i] != UNIT_CNT_W'(TIMEOUT_UNIT_MS - 1)) begin
            unit_ms_r[i] <= unit_ms_r[i] + 1'b1;
          end else begin
            unit_ms_r[i] <= '0;
            tmo_cnt_r[i] <= tmo_cnt_r[i] - 1'b1;
            if (tmo_cnt_r[i] == TMO_W'(1)) begin
              pass_active_r[i] <= 1'b0;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      line_pass_hit_out <= 1'b0;
    end else if (ce_in) begin
      line_pass_hit_out <= pass_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host forwarding
  // non-matching samples are still taken in and, in framed mode only, forwarded
  assign forward = rx_sample_valid_in && api_mode_in
                   && !(src_match && !sample_output_enable_in);

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      host_frame_valid_out <= 1'b0;
      host_frame_src_out <= '0;
      host_frame_mask_out <= '0;
      host_frame_data_out <= '0;
    end else if (ce_in) begin
      host_frame_valid_out <= forward;
      if (forward) begin
        host_frame_src_out <= rx_sample_src_in;
        host_frame_mask_out <= rx_sample_mask_in;
        host_frame_data_out <= rx_sample_data_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, including sleep behaviour
  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pin_out <= '0;
      pin_oe_out <= '0;
      pin_pull_en_out <= '0;
      pin_pull_up_out <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_oe_out[i] <= iocd_is_output(pin_mode_in[i]);
        pin_out[i] <= pass_active_r[i] ? pass_level_r[i]
                      : (pin_mode_in[i] == MODE_OUT_HIGH);
        pin_pull_en_out[i] <= pull_enable_mask_in[i]
                              && !iocd_is_output(pin_mode_in[i]);
        pin_pull_up_out[i] <= pull_direction_mask_in[i];
      end
    end
  end

  // parked levels cut sleep leakage
  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      periph_out <= '0;
      spi_out <= '1;
    end else if (ce_in) begin
      periph_out <= asleep ? '0 : periph_func_in;
      spi_out <= asleep ? '1 : spi_func_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receive buffer; clear-to-send is not parked in sleep
  assign rxb.wr_valid = ser_rx_valid_in;
  assign rxb.wr_data = ser_rx_byte_in;
  assign rxb.rd_ready = ser_byte_ready_in;
  assign ser_rx_drop_out = rxb.drop;
  assign ser_byte_valid_out = rxb.rd_valid;
  assign ser_byte_out = rxb.rd_data;
  assign cts_n_out = rxb.cts_n;

  iocd_rx_buf u_rx_buf (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_r),
    .ce_in(ce_in),
    .bus(rxb.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial transmit space accounting
  // only occupancy is kept; the payload path lies outside this block
  assign tx_free = TXB_CAPACITY + SYS_CAPACITY - tx_level_r;
  assign tx_fits = (TXB_CNT_W'(rf_pkt_len_in) <= tx_free);
  assign tx_dec = ser_tx_byte_sent_in && (tx_level_r != '0);
  assign tx_level_out = tx_level_r;

  always_ff @(posedge clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      tx_level_r <= '0;
      rf_pkt_accept_out <= 1'b0;
      rf_pkt_drop_out <= 1'b0;
    end else if (ce_in) begin
      rf_pkt_accept_out <= rf_pkt_valid_in && tx_fits;
      rf_pkt_drop_out <= rf_pkt_valid_in && !tx_fits;
      tx_level_r <= tx_level_r
                    + ((rf_pkt_valid_in && tx_fits) ? TXB_CNT_W'(rf_pkt_len_in) : '0)
                    - TXB_CNT_W'(tx_dec);
    end
  end
endmodule

//--- common/iocd_pkg.sv
package iocd_pkg;
  localparam int NUM_PINS = 13;
  localparam int NUM_GEN_PINS = 10;
  localparam int ADDR_W = 16;
  localparam int TMO_W = 8;
  localparam int PERIOD_W = 16;
  localparam int SLEEP_W = 3;
  localparam int PERIPH_W = 4;
  localparam int SPI_W = 4;
  localparam logic [ADDR_W-1:0] BROADCAST_ADDR = 16'hffff;
  localparam logic [PERIOD_W-1:0] PERIOD_OFF = 16'h0000;
  localparam logic [SLEEP_W-1:0] SLEEP_AWAKE = 3'h0;
  localparam logic [TMO_W-1:0] TMO_HOLD = 8'h00;
  // pin modes
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_INPUT = 2'h1;
  localparam logic [1:0] MODE_OUT_LOW = 2'h2;
  localparam logic [1:0] MODE_OUT_HIGH = 2'h3;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_UNIT_MS = 100;
  localparam int MS_CNT_W = 16;
  localparam int UNIT_CNT_W = 7;
  // serial receive buffer
  localparam int RXB_DEPTH = 16;
  localparam int RXB_PTR_W = 4;
  localparam int RXB_CNT_W = 5;
  localparam logic [RXB_CNT_W-1:0] RXB_FLOW_THRESH = 5'h0c;
  // serial transmit and system buffers, in bytes
  localparam int TXB_CNT_W = 10;
  localparam int PKT_LEN_W = 8;
  localparam logic [TXB_CNT_W-1:0] TXB_CAPACITY = 10'h100;
  localparam logic [TXB_CNT_W-1:0] SYS_CAPACITY = 10'h100;

  function automatic logic iocd_is_output(input logic [1:0] mode);
    return (mode == MODE_OUT_LOW) || (mode == MODE_OUT_HIGH);
  endfunction
endpackage

//--- common/iocd_buf_if.sv
`timescale 1ns/100ps
interface iocd_buf_if;
  logic wr_valid;
  logic [7:0] wr_data;
  logic drop;
  logic rd_valid;
  logic rd_ready;
  logic [7:0] rd_data;
  logic cts_n;
  modport store (input wr_valid, input wr_data, input rd_ready,
                 output drop, output rd_valid, output rd_data, output cts_n);
  modport user (output wr_valid, output wr_data, output rd_ready,
                input drop, input rd_valid, input rd_data, input cts_n);
endinterface

//--- design/iocd_tick.sv
`timescale 1ns/100ps
module iocd_tick
  import iocd_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic run_in,
  output logic ms_tick_out,
  output logic unit_tick_out
);
  logic [MS_CNT_W-1:0] cyc_r;
  logic [UNIT_CNT_W-1:0] ms_r;

  assign ms_tick_out = run_in && (cyc_r == MS_CNT_W'(CYC_PER_MS - 1));
  assign unit_tick_out = ms_tick_out && (ms_r == UNIT_CNT_W'(TIMEOUT_UNIT_MS - 1));

  // frozen while asleep so timeouts resume where they stopped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc_r <= '0;
      ms_r <= '0;
    end else if (ce_in && run_in) begin
      cyc_r <= ms_tick_out ? '0 : cyc_r + 1'b1;
      if (ms_tick_out) begin
        ms_r <= unit_tick_out ? '0 : ms_r + 1'b1;
      end
    end
  end
endmodule

//--- design/iocd_rx_buf.sv
`timescale 1ns/100ps
module iocd_rx_buf
  import iocd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  iocd_buf_if.store bus
);
  logic [7:0] mem_r [RXB_DEPTH];
  logic [RXB_PTR_W-1:0] wr_ptr_r;
  logic [RXB_PTR_W-1:0] rd_ptr_r;
  logic [RXB_CNT_W-1:0] cnt_r;
  logic full;
  logic do_wr;
  logic do_rd;
  logic cts_n_r;

  assign full = (cnt_r == RXB_CNT_W'(RXB_DEPTH));
  assign do_wr = bus.wr_valid && !full;
  assign do_rd = bus.rd_ready && (cnt_r != '0);
  assign bus.rd_valid = (cnt_r != '0);
  assign bus.rd_data = mem_r[rd_ptr_r];
  assign bus.drop = bus.wr_valid && full;
  assign bus.cts_n = cts_n_r;

  always_ff @(posedge clk_in) begin
    if (ce_in && do_wr) begin
      mem_r[wr_ptr_r] <= bus.wr_data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else if (ce_in) begin
      if (do_wr) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_rd) rd_ptr_r <= rd_ptr_r + 1'b1;
      cnt_r <= cnt_r + RXB_CNT_W'(do_wr) - RXB_CNT_W'(do_rd);
    end
  end

  // hysteresis stops chatter at the threshold
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cts_n_r <= 1'b0;
    end else if (ce_in) begin
      if (cnt_r > RXB_FLOW_THRESH) cts_n_r <= 1'b1;
      else if (cnt_r < RXB_FLOW_THRESH) cts_n_r <= 1'b0;
    end
  end
endmodule

//--- testbench/iocd_top_sva.sv
`timescale 1ns/100ps
module iocd_top_sva
  import iocd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [SLEEP_W-1:0] sleep_mode_setting_in,
  input wire logic api_mode_in,
  input wire logic [NUM_PINS-1:0] change_detect_mask_in,
  input wire logic [ADDR_W-1:0] input_source_address_in,
  input wire logic sample_output_enable_in,
  input wire logic [NUM_PINS-1:0][1:0] pin_mode_in,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic sample_valid_out,
  input wire logic [NUM_PINS-1:0] sample_data_out,
  input wire logic rx_sample_valid_in,
  input wire logic [ADDR_W-1:0] rx_sample_src_in,
  input wire logic [NUM_PINS-1:0] rx_sample_mask_in,
  input wire logic [NUM_PINS-1:0] rx_sample_data_in,
  input wire logic host_frame_valid_out,
  input wire logic [ADDR_W-1:0] host_frame_src_out,
  input wire logic line_pass_hit_out,
  input wire logic ser_rx_valid_in,
  input wire logic ser_rx_drop_out,
  input wire logic cts_n_out,
  input wire logic rf_pkt_valid_in,
  input wire logic rf_pkt_accept_out,
  input wire logic rf_pkt_drop_out,
  input wire logic [SPI_W-1:0] spi_out,
  input wire logic [PERIPH_W-1:0] periph_out
);
  logic [1:0] age_r;
  logic match, fwd, asleep, was_asleep;
  logic [NUM_PINS-1:0] pmask;
  // design outputs lag reset release by two edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  always_ff @(posedge clk_in) was_asleep <= asleep;
  assign asleep = sleep_mode_setting_in != SLEEP_AWAKE;
  assign match = (rx_sample_src_in == input_source_address_in)
               || (input_source_address_in == BROADCAST_ADDR);
  assign fwd = api_mode_in && !(match && !sample_output_enable_in);
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) pmask[i] = rx_sample_mask_in[i] & pin_mode_in[i][1];
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in || age_r != 2'h3);
  ////////////////////////////////////////////////////////////////////////
  a_change_fires: assert property (
    ce_in && !asleep && !was_asleep
    && ((pin_in ^ $past(pin_in)) & change_detect_mask_in) != '0 |=> sample_valid_out)
    else $error("masked change gave no sample");
  a_sleep_quiet: assert property (
    asleep && was_asleep |=> !sample_valid_out)
    else $error("sample while asleep");
  a_sample_data: assert property (
    sample_valid_out |-> sample_data_out == $past(pin_in))
    else $error("sample data wrong");
  a_hit_match: assert property (
    rx_sample_valid_in && ce_in |=> line_pass_hit_out == $past(match))
    else $error("hit does not follow source match");
  a_frame_route: assert property (
    rx_sample_valid_in && ce_in |=> host_frame_valid_out == $past(fwd))
    else $error("host frame routing wrong");
  a_frame_src: assert property (
    host_frame_valid_out |-> host_frame_src_out == $past(rx_sample_src_in))
    else $error("host frame source wrong");
  a_pass_level: assert property (
    rx_sample_valid_in && ce_in && match && !asleep
    |-> ##2 ((pin_out ^ $past(rx_sample_data_in, 2)) & $past(pmask, 2)) == '0)
    else $error("passed level not driven");
  a_drop_full: assert property (
    ser_rx_drop_out |-> ser_rx_valid_in && cts_n_out)
    else $error("drop without full buffer");
  a_sleep_pins: assert property (
    asleep && was_asleep |-> spi_out == '1 && periph_out == '0)
    else $error("sleep pin levels wrong");
  a_rf_answer: assert property (
    rf_pkt_valid_in && ce_in |=> rf_pkt_accept_out != rf_pkt_drop_out)
    else $error("packet not answered once");
endmodule
bind iocd_top iocd_top_sva iocd_top_sva_i (.*);

//--- testbench/iocd_far_node.sv
`timescale 1ns/100ps
module iocd_far_node
  import iocd_pkg::*;
(
  input wire logic clk_in,
  input wire logic cts_n_in,
  output logic rx_valid_out,
  output logic [ADDR_W-1:0] rx_src_out,
  output logic [NUM_PINS-1:0] rx_mask_out,
  output logic [NUM_PINS-1:0] rx_data_out,
  output logic ser_valid_out,
  output logic [7:0] ser_byte_out
);
  initial begin
    rx_valid_out = 1'b0;
    rx_src_out = 16'h0000;
    rx_mask_out = 13'h0000;
    rx_data_out = 13'h0000;
    ser_valid_out = 1'b0;
    ser_byte_out = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic send_sample(input logic [ADDR_W-1:0] src, input logic [NUM_PINS-1:0] m, d);
    @(negedge clk_in);
    rx_valid_out = 1'b1;
    rx_src_out = src;
    rx_mask_out = m;
    rx_data_out = d;
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    // scrambled so stale fields never pass
    rx_src_out = ~src;
    rx_mask_out = ~m;
    rx_data_out = ~d;
  endtask
  // honour_cts low overruns the buffer on purpose
  task automatic send_bytes(input int n, input logic [7:0] base, input logic honour_cts);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      while (honour_cts && cts_n_in) @(negedge clk_in);
      ser_valid_out = 1'b1;
      ser_byte_out = base + 8'(i);
      @(negedge clk_in);
      ser_valid_out = 1'b0;
      ser_byte_out = ~ser_byte_out;
    end
  endtask
endmodule

//--- testbench/io_change_detect_line_passing_tb.sv
`timescale 1ns/100ps
module io_change_detect_line_passing_tb;
  import iocd_pkg::*;
  logic clk_in, rst_n_in, ce_in, api_mode_in, sample_output_enable_in, ser_byte_ready_in;
  logic [SLEEP_W-1:0] sleep_mode_setting_in;
  logic [NUM_PINS-1:0] change_detect_mask_in, pull_enable_mask_in, pull_direction_mask_in;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_out, pin_pull_en_out, pin_pull_up_out;
  logic [NUM_PINS-1:0] sample_data_out, rx_sample_mask_in, rx_sample_data_in;
  logic [NUM_PINS-1:0] host_frame_mask_out, host_frame_data_out;
  logic [PERIOD_W-1:0] sample_period_ms_in;
  logic [ADDR_W-1:0] input_source_address_in, rx_sample_src_in, host_frame_src_out;
  logic [NUM_PINS-1:0][1:0] pin_mode_in;
  logic [NUM_PINS-1:0][TMO_W-1:0] pass_timeout_in;
  logic sample_valid_out, rx_sample_valid_in, host_frame_valid_out, line_pass_hit_out;
  logic ser_rx_valid_in, ser_rx_drop_out, ser_byte_valid_out, cts_n_out, rf_pkt_valid_in;
  logic rf_pkt_accept_out, rf_pkt_drop_out, ser_tx_byte_sent_in, asleep_out;
  logic [7:0] ser_rx_byte_in, ser_byte_out;
  logic [PKT_LEN_W-1:0] rf_pkt_len_in;
  logic [TXB_CNT_W-1:0] tx_level_out;
  logic [PERIPH_W-1:0] periph_func_in, periph_out;
  logic [SPI_W-1:0] spi_func_in, spi_out;
  int mismatches, compares, cyc, nsamp, nhit, nframe, ndrop;

  iocd_top #(.CYC_PER_MS(20)) iocd_top_i (.*);
  iocd_far_node iocd_far_node_i (.clk_in, .cts_n_in(cts_n_out),
    .rx_valid_out(rx_sample_valid_in), .rx_src_out(rx_sample_src_in),
    .rx_mask_out(rx_sample_mask_in), .rx_data_out(rx_sample_data_in),
    .ser_valid_out(ser_rx_valid_in), .ser_byte_out(ser_rx_byte_in));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    nsamp += int'(sample_valid_out === 1'b1);
    nhit += int'(line_pass_hit_out === 1'b1);
    nframe += int'(host_frame_valid_out === 1'b1);
    ndrop += int'(ser_rx_drop_out === 1'b1);
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_change;
    int n0;
    n0 = nsamp;
    pin_in[5] = ~pin_in[5];
    wait_cyc(3);
    chk(nsamp - n0, 0);
    pin_in[3] = ~pin_in[3];
    wait_cyc(2);
    chk(nsamp - n0, 1);
    chk(sample_data_out, pin_in);
    $display("change test done");
  endtask
  task automatic t_period;
    int n0;
    sample_period_ms_in = 16'h0002;
    wait_cyc(50);
    n0 = nsamp;
    wait_cyc(400);
    chk(nsamp - n0, 10);
    sample_period_ms_in = PERIOD_OFF;
    wait_cyc(50);
    n0 = nsamp;
    wait_cyc(400);
    chk(nsamp - n0, 0);
    $display("period test done");
  endtask
  task automatic t_sleep;
    int n0;
    sample_period_ms_in = 16'hffff;
    sleep_mode_setting_in = 3'h1;
    wait_cyc(3);
    chk(asleep_out, 1);
    chk({spi_out, periph_out}, 8'hf0);
    chk({pin_oe_out[0], pin_out[0]}, 2'h3);
    chk({pin_pull_en_out[4], pin_pull_up_out[4]}, 2'h3);
    n0 = nsamp;
    pin_in[3] = ~pin_in[3];
    wait_cyc(5);
    chk(nsamp - n0, 0);
    sleep_mode_setting_in = SLEEP_AWAKE;
    wait_cyc(3);
    chk(nsamp - n0, 1);
    chk({spi_out, periph_out}, {spi_func_in, periph_func_in});
    sample_period_ms_in = PERIOD_OFF;
    $display("sleep test done");
  endtask
  task automatic rx(input logic [ADDR_W-1:0] src, input logic d, input int eh, ef,
                    input logic ep);
    int h0, f0;
    h0 = nhit;
    f0 = nframe;
    iocd_far_node_i.send_sample(src, 13'h0404, d ? 13'h0404 : 13'h0000);
    wait_cyc(3);
    chk(nhit - h0, eh);
    chk(nframe - f0, ef);
    if (ef) chk({host_frame_mask_out, host_frame_data_out}, {13'h0404, iocd_far_node_i.rx_data_out ^ 13'h1fff});
    chk(pin_out & 13'h0404, ep ? 13'h0404 : 13'h0000);
  endtask
  task automatic t_filter;
    pass_timeout_in[2] = TMO_HOLD;
    pass_timeout_in[10] = TMO_HOLD;
    sample_output_enable_in = 1'b0;
    rx(16'h5678, 1'b1, 0, 1, 1'b0);
    rx(16'h1234, 1'b1, 1, 0, 1'b1);
    api_mode_in = 1'b0;
    rx(16'h5678, 1'b0, 0, 0, 1'b1);
    input_source_address_in = BROADCAST_ADDR;
    rx(16'h5678, 1'b0, 1, 0, 1'b0);
    api_mode_in = 1'b1;
    sample_output_enable_in = 1'b1;
    input_source_address_in = 16'h1234;
    $display("filter test done");
  endtask
  task automatic t_pass;
    pass_timeout_in[2] = 8'h01;
    rx(16'h1234, 1'b1, 1, 1, 1'b1);
    wait_cyc(1000);
    rx(16'h1234, 1'b1, 1, 1, 1'b1);
    wait_cyc(1500);
    chk(pin_out[2], 1);
    sleep_mode_setting_in = 3'h2;
    wait_cyc(1000);
    chk(pin_out[2], 1);
    sleep_mode_setting_in = SLEEP_AWAKE;
    wait_cyc(300);
    chk(pin_out[2], 1);
    wait_cyc(300);
    chk(pin_out[2], 0);
    $display("pass test done");
  endtask
  task automatic t_serial;
    int d0;
    d0 = ndrop;
    iocd_far_node_i.send_bytes(13, 8'h40, 1'b1);
    wait_cyc(2);
    chk(cts_n_out, 1);
    iocd_far_node_i.send_bytes(5, 8'h4d, 1'b0);
    wait_cyc(1);
    chk(ndrop - d0, 2);
    for (int i = 0; i < 16; i++) begin
      chk({ser_byte_valid_out, ser_byte_out}, {1'b1, 8'h40 + 8'(i)});
      ser_byte_ready_in = 1'b1;
      @(negedge clk_in);
    end
    ser_byte_ready_in = 1'b0;
    wait_cyc(2);
    chk({ser_byte_valid_out, cts_n_out}, 2'h0);
    $display("serial test done");
  endtask
  task automatic rf(input logic [7:0] len, input logic acc, input logic [9:0] lvl);
    @(negedge clk_in);
    rf_pkt_valid_in = 1'b1;
    rf_pkt_len_in = len;
    @(negedge clk_in);
    rf_pkt_valid_in = 1'b0;
    rf_pkt_len_in = ~len;
    chk({rf_pkt_accept_out, rf_pkt_drop_out, tx_level_out}, {acc, ~acc, lvl});
  endtask
  task automatic t_rf;
    rf(8'hff, 1'b1, 10'h0ff);
    rf(8'hff, 1'b1, 10'h1fe);
    rf(8'h03, 1'b0, 10'h1fe);
    rf(8'h02, 1'b1, 10'h200);
    ser_tx_byte_sent_in = 1'b1;
    @(negedge clk_in);
    ser_tx_byte_sent_in = 1'b0;
    wait_cyc(1);
    chk(tx_level_out, 10'h1ff);
    $display("rf test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_in, ser_byte_ready_in, rf_pkt_valid_in, ser_tx_byte_sent_in} = 4'h0;
    {ce_in, api_mode_in, sample_output_enable_in} = 3'h7;
    sleep_mode_setting_in = SLEEP_AWAKE;
    change_detect_mask_in = 13'h0008;
    sample_period_ms_in = PERIOD_OFF;
    input_source_address_in = 16'h1234;
    pin_mode_in = '0;
    pin_mode_in[0] = MODE_OUT_HIGH;
    pin_mode_in[2] = MODE_OUT_LOW;
    pin_mode_in[10] = MODE_OUT_LOW;
    pin_mode_in[3] = MODE_INPUT;
    pass_timeout_in = '0;
    pull_enable_mask_in = 13'h0010;
    pull_direction_mask_in = 13'h0010;
    pin_in = 13'h0000;
    rf_pkt_len_in = 8'h00;
    periph_func_in = 4'h5;
    spi_func_in = 4'ha;
    wait_cyc(6);
    chk({spi_out, cts_n_out, sample_valid_out, pin_out}, {4'hf, 15'h0000});
    rst_n_in = 1'b1;
    wait_cyc(4);
    t_change();
    t_period();
    t_sleep();
    t_filter();
    t_pass();
    t_serial();
    t_rf();
    end_sim();
  end
endmodule
